//--- kei_params.svh
// Purpose: Offsets, field positions and reset values of the key interrupt block
// Assumes: Byte-wide registers on a plain strobe port
// Notes:   Included by bare name
`ifndef KEI_PARAMS_SVH
`define KEI_PARAMS_SVH
`define KEI_ADDR_W        2
`define KEI_OFS_STATCTRL  2'h0
`define KEI_OFS_PINEN     2'h1
`define KEI_OFS_PINSTATE  2'h2
`define KEI_BIT_MODE      0
`define KEI_BIT_IRQEN     1
`define KEI_BIT_ACK       2
`define KEI_BIT_PEND      3
`define KEI_POL_LO        4
`define KEI_POL_HI        7
`define KEI_RST_POL       4'h0
`define KEI_RST_PINEN     8'h00
`define KEI_RST_BYTE      8'h00
`define KEI_FIXED_PINS    4
`endif

//--- kei_pkg.sv
// Purpose: Types of the key interrupt block
// Assumes: Constants live in kei_params.svh
// Notes:   Detection mode enumeration and control struct
package kei_pkg;
  // Detection mode
  typedef enum logic {
    KEI_EDGE_ONLY  = 1'b0,
    KEI_EDGE_LEVEL = 1'b1
  } kei_mode_e;
  // Software controls
  typedef struct packed {
    logic [3:0] polHigh;   // Polarity of pins 7..4
    logic       irqEnable; // Request enable
    kei_mode_e  mode;      // Detection mode
  } kei_ctrl_s;
endpackage : kei_pkg

//--- kei_pin_sync.sv
// Purpose: Two-stage synchroniser with previous-sample stage for one key pin
// Assumes: Pin reset level is high (idle key)
// Notes:   First stage feeds only the second stage
module kei_pin_sync (
  input  wire logic ref_clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      syncOut,
  output logic      prevOut
);
  logic meta_q;   // First stage
  logic meta_d;
  logic sync_q;   // Second stage
  logic sync_d;
  logic prev_q;   // Previous sample
  logic prev_d;

  // Next values of the chain
  always_comb begin
    meta_d = pinIn;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Register the chain
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign syncOut = sync_q;
  assign prevOut = prev_q;
endmodule : kei_pin_sync

//--- kei_keypad_interrupt.sv
// What this block does
// - Pins 7..4 polarity bit picks trigger
// - Pins 3..0 falling edge or low only
// - Enabled pin trigger sets pending flag
// - Ack write clears; pending not writable
// - Level mode holds pending while asserted
// - Ack bit always reads zero
// - Request when pending and enable high
// - Mode bit: edge only or edge-and-level
//
// Purpose: Key pin interrupt with status/control, pin enable and pin state registers
// Assumes: Byte registers on a plain strobe port, read data one cycle after strobe
// Notes:   Unmapped reads return zero, unmapped writes are ignored
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "kei_params.svh"
module kei_keypad_interrupt #(
  parameter int PINS = 8
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  input  wire logic [PINS-1:0]      keyPin,
  input  wire logic [`KEI_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]           regWdata,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output logic      [7:0]           regRdata,
  output logic                      keypadInterrupt
);
  logic [PINS-1:0]  syncPin;      // Synchronised levels
  logic [PINS-1:0]  prevPin;      // Previous samples
  logic [PINS-1:0]  assertLevel;  // Pin at asserted level
  logic [PINS-1:0]  wasAsserted;  // Previous sample asserted
  logic [PINS-1:0]  activePol;    // 1 = high/rising
  logic             trigger;      // Any enabled trigger
  logic             ackWrite;     // Acknowledge write
  logic             ctrlWrite;    // Status/control write
  kei_pkg::kei_ctrl_s ctrl_q;     // Control fields
  kei_pkg::kei_ctrl_s ctrl_d;
  logic [PINS-1:0]  pinEnable_q;  // key_pin_enable
  logic [PINS-1:0]  pinEnable_d;
  logic             pending_q;    // key_event_pending
  logic             pending_d;
  logic             trig_q;       // Registered detection
  logic             trig_d;
  logic [7:0]       rdata_q;      // Read data
  logic [7:0]       rdata_d;
  logic [7:0]       statByte;     // Status/control readback

  // One synchroniser per pin
  for (genvar i = 0; i < PINS; i++) begin : gSync
    kei_pin_sync uSync (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .pinIn   (keyPin[i]),
      .syncOut (syncPin[i]),
      .prevOut (prevPin[i])
    );
  end

  // Polarity per pin: low pins fixed falling
  always_comb begin
    activePol = '0;
    for (int i = `KEI_FIXED_PINS; i < PINS; i++) begin
      activePol[i] = ctrl_q.polHigh[i-`KEI_FIXED_PINS];
    end
  end

  // Trigger detection over enabled pins
  always_comb begin
    assertLevel = ~(syncPin ^ activePol);
    wasAsserted = ~(prevPin ^ activePol);
    // Edge: newly asserted; level mode adds steady assertion
    if (ctrl_q.mode == kei_pkg::KEI_EDGE_LEVEL) begin
      trigger = |(pinEnable_q & assertLevel);
    end else begin
      trigger = |(pinEnable_q & assertLevel & ~wasAsserted);
    end
  end

  assign ctrlWrite = regWrite && (regAddr == `KEI_OFS_STATCTRL);
  assign ackWrite  = ctrlWrite && regWdata[`KEI_BIT_ACK];

  // Next state of flag and control
  always_comb begin
    trig_d      = trigger;
    ctrl_d      = ctrl_q;
    pinEnable_d = pinEnable_q;
    pending_d   = pending_q;
    if (ctrlWrite) begin
      ctrl_d.polHigh   = regWdata[`KEI_POL_HI:`KEI_POL_LO];
      ctrl_d.irqEnable = regWdata[`KEI_BIT_IRQEN];
      ctrl_d.mode      = kei_pkg::kei_mode_e'(regWdata[`KEI_BIT_MODE]);
    end
    if (regWrite && (regAddr == `KEI_OFS_PINEN)) begin
      pinEnable_d = regWdata[PINS-1:0];
    end
    // Clear first, then set so set wins
    if (ackWrite) begin
      pending_d = 1'b0;
    end
    if (trig_q) begin
      pending_d = 1'b1;
    end
  end

  // Readback assembly
  always_comb begin
    statByte = {ctrl_q.polHigh, pending_q, 1'b0,
                ctrl_q.irqEnable, ctrl_q.mode};
    rdata_d  = 8'h00;
    if (regRead) begin
      case (regAddr)
        `KEI_OFS_STATCTRL: rdata_d = statByte;
        `KEI_OFS_PINEN:    rdata_d = 8'(pinEnable_q);
        `KEI_OFS_PINSTATE: rdata_d = 8'(syncPin);
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  // Register all state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q      <= '{polHigh: `KEI_RST_POL, irqEnable: 1'b0,
                       mode: kei_pkg::KEI_EDGE_ONLY};
      pinEnable_q <= '0;
      pending_q   <= 1'b0;
      trig_q      <= 1'b0;
      rdata_q     <= `KEI_RST_BYTE;
    end else begin
      ctrl_q      <= ctrl_d;
      pinEnable_q <= pinEnable_d;
      pending_q   <= pending_d;
      trig_q      <= trig_d;
      rdata_q     <= rdata_d;
    end
  end

  assign regRdata        = rdata_q;
  assign keypadInterrupt = pending_q && ctrl_q.irqEnable;
endmodule : kei_keypad_interrupt

//--- kei_keypad_interrupt_monitor.sv
// Purpose: Port checks for the key interrupt block
// Assumes: Shadows follow control writes
// Notes:   Bound to the top module
module kei_keypad_interrupt_monitor #(
  parameter int PINS = 8
) (
  input wire logic            ref_clk,
  input wire logic            reset_n,
  input wire logic [PINS-1:0] keyPin,
  input wire logic [1:0]      regAddr,
  input wire logic [7:0]      regWdata,
  input wire logic            regWrite,
  input wire logic            regRead,
  input wire logic [7:0]      regRdata,
  input wire logic            keypadInterrupt
);
  logic [7:0] ctlQ, enQ; // Shadow control and pin enables
  wire        w0 = regWrite && regAddr == 2'h0;
  // Track software settings
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) {ctlQ, enQ} <= 16'h0000;
    else begin
      if (w0) ctlQ <= regWdata & 8'hF3;
      if (regWrite && regAddr == 2'h1) enQ <= regWdata;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Status readback matches the shadow, ack bit reads zero
  property p_rd;
    regRead && regAddr == 2'h0 |=> (regRdata & 8'hF7) == $past(ctlQ);
  endproperty
  a_rd: assert property (p_rd) else $error("ctrl readback");
  // Pending bit agrees with the request while enabled
  property p_pnd;
    regRead && regAddr == 2'h0 && ctlQ[1] |=> regRdata[3] == $past(keypadInterrupt);
  endproperty
  a_pnd: assert property (p_pnd) else $error("pending readback");
  // No request with the enable low
  property p_off;
    !ctlQ[1] |-> !keypadInterrupt;
  endproperty
  a_off: assert property (p_off) else $error("request while disabled");
  // Enable already high, so only a set flag could raise the request
  property p_noEn;
    (enQ == 8'h00)[*4] ##0 ctlQ[1] && !keypadInterrupt |=> !keypadInterrupt;
  endproperty
  a_noEn: assert property (p_noEn) else $error("disabled pin set flag");
  // Falling edge on a low pin reaches the request in four cycles
  property p_fall;
    $fell(keyPin[0]) && enQ[0] && ctlQ[1] |-> ##4 keypadInterrupt;
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge missed");
  // Rising edge on a high pin with polarity high
  property p_rise;
    $rose(keyPin[4]) && enQ[4] && ctlQ[4] && ctlQ[1] |-> ##4 keypadInterrupt;
  endproperty
  a_rise: assert property (p_rise) else $error("rising edge missed");
  // Held low level keeps the flag up in level mode
  property p_lvl;
    (ctlQ[0] && ctlQ[1] && enQ[0] && !keyPin[0])[*4] ##1 ctlQ[1] |-> keypadInterrupt;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level not held");
  // Edge mode settled and pins quiet: ack clears the flag
  property p_ack;
    ($stable(keyPin) && !ctlQ[0])[*5] ##0 w0 && regWdata[2:0] == 3'h6 |=> !keypadInterrupt;
  endproperty
  a_ack: assert property (p_ack) else $error("ack did not clear");
  cover property (w0 && regWdata[2]);
  cover property ($rose(keypadInterrupt));
  cover property (regRead && regAddr == 2'h3);
endmodule : kei_keypad_interrupt_monitor
bind kei_keypad_interrupt kei_keypad_interrupt_monitor #(.PINS(PINS)) kei_keypad_interrupt_monitor_i (
  .ref_clk, .reset_n, .keyPin, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .keypadInterrupt);

//--- kei_key_model.sv
// Purpose: Key switch model
// Assumes: Contacts settle each clock
// Notes:   Bench commands the levels
module kei_key_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] keySet,
  output logic      [7:0] keyPin
);
  initial keyPin = 8'hFF; // Keys idle high
  // Contacts follow the commanded level
  always @(posedge ref_clk) keyPin <= keySet;
endmodule : kei_key_model

//--- kei_keypad_interrupt_tb.sv
// Purpose: Register and key event tests
// Assumes: Keys idle high
// Notes:   Pending seen by status reads
module kei_keypad_interrupt_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, kI;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00, keySet = 8'hFF, regRdata, keyPin;
  int         num_errors = 0, num_checks = 0, cyc = 0;
  kei_key_model kei_key_model_i (.ref_clk, .keySet, .keyPin);
  kei_keypad_interrupt kei_keypad_interrupt_i (.ref_clk, .reset_n, .keyPin, .regAddr,
    .regWdata, .regWrite, .regRead, .regRdata, .keypadInterrupt(kI));
  always #4 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  task chk(string n, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(logic [1:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge ref_clk);
    regWrite <= 1'h0;
  endtask : wr
  task rd(logic [1:0] a, logic [7:0] e);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge ref_clk);
    regRead <= 1'h0;
    #1 chk("rdata", e, regRdata);
  endtask : rd
  // Set keys, let them settle, check request
  task key(logic [7:0] v, logic e);
    @(posedge ref_clk);
    keySet <= v;
    repeat (8) @(posedge ref_clk);
    #1 chk("irq", {7'h00, e}, {7'h00, kI});
  endtask : key
  task summarize;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'h1;
    rd(2'h0, 8'h00);
    rd(2'h2, 8'hFF);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'hF3);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(2'h0, 8'h02);
    key(8'hFE, 1'h0);
    wr(2'h1, 8'h11);
    key(8'hFF, 1'h0);
    key(8'hFE, 1'h1);
    rd(2'h0, 8'h0A);
    wr(2'h0, 8'h06);
    rd(2'h0, 8'h02);
    wr(2'h0, 8'h12);
    key(8'hEE, 1'h0);
    key(8'hFE, 1'h1);
    wr(2'h0, 8'h13);
    wr(2'h0, 8'h17);
    rd(2'h0, 8'h1B);
    wr(2'h0, 8'h15);
    key(8'hFE, 1'h0);
    rd(2'h0, 8'h19);
    key(8'hEF, 1'h0);
    rd(2'h2, 8'hEF);
    wr(2'h0, 8'h17);
    rd(2'h0, 8'h13);
    summarize();
  end
endmodule : kei_keypad_interrupt_tb
